// ==== core/host_port_pkg.sv ====
// constants and types shared by the split-strobe host bus port
// assumes a single 250 MHz clock, with all host pins synchronous to it
`default_nettype none
package host_port_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;  // one 256K byte block per space
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_LSB = 0;  // byte select bit

  // ----------------------------------------------------------------
  // byte lane enables
  // ----------------------------------------------------------------
  localparam logic [1:0] LANE_NONE = 2'h0;
  localparam logic [1:0] LANE_LO = 2'h1;
  localparam logic [1:0] LANE_HI = 2'h2;
  localparam logic [1:0] LANE_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // space select and strap meanings
  // ----------------------------------------------------------------
  localparam logic SPACE_REG = 1'b0;  // first block
  localparam logic SPACE_MEM = 1'b1;  // second block
  localparam logic POL_ACTIVE_HIGH = 1'b1;
  localparam logic DIV_TWO = 1'b1;  // 2:1, else 1:1

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic WAIT_PIN_RESET = 1'b1;  // released for active low
  localparam logic OE_N_RESET = 1'b1;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [17:0] ADDR_RESET = 18'h00000;

  // ----------------------------------------------------------------
  // access sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARB = 2'b01,
    ST_DONE = 2'b10
  } port_state_e;

endpackage
`default_nettype wire

// ==== core/port_cfg_if.sv ====
// strap results and internal bus clock enable passed to the sequencer
// assumes one clock domain on both ends
`timescale 1ns/1ns
`default_nettype none
interface port_cfg_if;
  logic valid;  // straps captured
  logic hold_pol;  // wait level when holding the host
  logic big_endian;
  logic bus_en;  // internal bus / memory clock enable

  modport src (output valid, hold_pol, big_endian, bus_en);
  modport dst (input valid, hold_pol, big_endian, bus_en);
endinterface
`default_nettype wire

// ==== core/strap_clock_gen.sv ====
// strap capture after reset release and internal bus clock enable divider
// assumes strap pins are stable around the release of rst_n_i
`timescale 1ns/1ns
`default_nettype none
module strap_clock_gen
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // straps
  input wire logic endian_strap_i,
  input wire logic hold_polarity_strap_i,
  input wire logic clk_div_strap_i,
  // results
  port_cfg_if.src cfg
);

  typedef struct packed {
    logic valid;
    logic hold_pol;
    logic big_endian;
    logic div2;
    logic phase;
    logic bus_en;
  } gen_s;

  gen_s r;
  gen_s next_r;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // straps read only once, in the first clock after release
  always_comb begin
    next_r = r;
    if (!r.valid) begin
      next_r.valid = 1'b1;
      next_r.hold_pol = hold_polarity_strap_i;
      next_r.big_endian = endian_strap_i;
      next_r.div2 = clk_div_strap_i;
    end
    // enable every cycle at 1:1, every second cycle at 2:1
    next_r.phase = r.div2 ? ~r.phase : 1'b0;
    next_r.bus_en = r.valid && (r.div2 != DIV_TWO || r.phase);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign cfg.valid = r.valid;
  assign cfg.hold_pol = r.hold_pol;
  assign cfg.big_endian = r.big_endian;
  assign cfg.bus_en = r.bus_en;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_strap_held;
    r.valid |=> $stable(r.div2) && $stable(r.hold_pol);
  endproperty
  a_strap_held: assert property (p_strap_held) else $error("straps changed after capture");

  property p_div_one;
    r.valid && $past(r.valid) && !r.div2 |=> r.bus_en;
  endproperty
  a_div_one: assert property (p_div_one) else $error("1:1 enable missing");

  property p_div_two;
    r.valid && r.div2 && r.bus_en |=> !r.bus_en ##1 r.bus_en;
  endproperty
  a_div_two: assert property (p_div_two) else $error("2:1 enable pattern wrong");

endmodule
`default_nettype wire

// ==== core/split_strobe_host_bus_port.sv ====
// split-strobe host bus slave port: host access to registers and display buffer
// assumes host pins synchronous to clock_i and an outside arbiter that
// acknowledges internal requests once display refresh yields the resource
`timescale 1ns/1ns
`default_nettype none

module split_strobe_host_bus_port
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // straps
  input wire logic endian_strap_i,
  input wire logic hold_polarity_strap_i,
  input wire logic clk_div_strap_i,
  // host bus
  input wire logic [ADDR_W-1:0] addr_in_i,
  input wire logic [DATA_W-1:0] data_io_i,
  output logic [DATA_W-1:0] data_io_o,
  output logic data_io_oe_n_o,
  input wire logic chip_sel_n_i,
  input wire logic mem_reg_sel_i,
  input wire logic high_byte_write_en_i,
  input wire logic low_write_en_i,
  input wire logic read_strobe_n_i,
  input wire logic cycle_begin_n_i,
  input wire logic dir_sel_n_i,
  output logic host_ready_in_o,
  // internal resource side
  output logic int_req_o,
  output logic int_we_o,
  output logic int_space_o,
  output logic [ADDR_W-1:0] int_addr_o,
  output logic [DATA_W-1:0] int_wdata_o,
  output logic [1:0] int_be_o,
  input wire logic int_ack_i,
  input wire logic [DATA_W-1:0] int_rdata_i
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // lane select from high byte enable (low = full word) and address bit 0
  function automatic logic [1:0] lanes(input logic hb_n, input logic a0);
    if (!hb_n) begin
      lanes = LANE_BOTH;
    end else begin
      lanes = a0 ? LANE_HI : LANE_LO;
    end
  endfunction

  // byte order swap; used for both directions
  function automatic logic [DATA_W-1:0] order(input logic [DATA_W-1:0] d, input logic big);
    order = big ? {d[BYTE_W-1:0], d[DATA_W-1:BYTE_W]} : d;
  endfunction

  port_cfg_if cfg ();

  strap_clock_gen u_gen (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .endian_strap_i(endian_strap_i),
    .hold_polarity_strap_i(hold_polarity_strap_i),
    .clk_div_strap_i(clk_div_strap_i),
    .cfg(cfg.src)
  );

  typedef struct packed {
    port_state_e st;
    logic wait_pin;
    logic oe_n;
    logic [DATA_W-1:0] dout;
    logic req;
    logic we;
    logic space;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] be;
  } port_s;

  port_s r;
  port_s next_r;

  // ----------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------
  // cycle begin and direction pins are ignored in this mode
  logic rd_act;
  logic wr_act;
  logic start;
  assign rd_act = !chip_sel_n_i && !read_strobe_n_i;
  assign wr_act = !chip_sel_n_i && !low_write_en_i;
  assign start = r.st == ST_IDLE && cfg.valid && (rd_act || wr_act);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    unique case (r.st)
      ST_IDLE: begin
        // idle level follows the strap once it is known
        next_r.wait_pin = cfg.valid ? ~cfg.hold_pol : WAIT_PIN_RESET;
        if (start) begin
          next_r.st = ST_ARB;
          next_r.wait_pin = cfg.hold_pol;
          next_r.we = wr_act && !rd_act;
          next_r.space = mem_reg_sel_i;
          next_r.addr = addr_in_i;
          next_r.wdata = order(data_io_i, cfg.big_endian);
          next_r.be = lanes(high_byte_write_en_i, addr_in_i[ADDR_LSB]);
        end
      end
      ST_ARB: begin
        // request moves only on internal bus clock edges
        if (cfg.bus_en) begin
          next_r.req = 1'b1;
          if (r.req && int_ack_i) begin
            // arbitration over: release wait with data on the same edge
            next_r.req = 1'b0;
            next_r.st = ST_DONE;
            next_r.wait_pin = ~cfg.hold_pol;
            if (!r.we) begin
              next_r.dout = order(int_rdata_i, cfg.big_endian);
              next_r.oe_n = 1'b0;
            end
          end
        end
      end
      ST_DONE: begin
        // hold read data until the host lets go of the strobes
        if (chip_sel_n_i || (read_strobe_n_i && low_write_en_i)) begin
          next_r.st = ST_IDLE;
          next_r.oe_n = OE_N_RESET;
        end
      end
      default: begin
        // unused code: back to idle with the data bus released
        next_r.st = ST_IDLE;
        next_r.oe_n = OE_N_RESET;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '{st: ST_IDLE, wait_pin: WAIT_PIN_RESET, oe_n: OE_N_RESET, dout: DATA_RESET,
             req: 1'b0, we: 1'b0, space: SPACE_REG, addr: ADDR_RESET, wdata: DATA_RESET,
             be: LANE_NONE};
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign host_ready_in_o = r.wait_pin;
  assign data_io_o = r.dout;
  assign data_io_oe_n_o = r.oe_n;
  assign int_req_o = r.req;
  assign int_we_o = r.we;
  assign int_space_o = r.space;
  assign int_addr_o = r.addr;
  assign int_wdata_o = r.wdata;
  assign int_be_o = r.be;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_granted;
    r.st == ST_ARB && cfg.bus_en && r.req && int_ack_i;
  endsequence

  sequence s_released;
    r.st == ST_DONE && r.wait_pin == ~cfg.hold_pol;
  endsequence

  property p_wait_on_start;
    start |=> r.wait_pin == cfg.hold_pol && r.st == ST_ARB;
  endproperty
  a_wait_on_start: assert property (p_wait_on_start) else $error("wait not raised on access");

  property p_wait_held;
    r.st == ST_ARB |-> r.wait_pin == cfg.hold_pol;
  endproperty
  a_wait_held: assert property (p_wait_held) else $error("wait dropped during arbitration");

  property p_grant_release;
    s_granted |=> s_released;
  endproperty
  a_grant_release: assert property (p_grant_release) else $error("wait not released on grant");

  property p_read_data_with_release;
    s_granted ##0 !r.we |=> !r.oe_n && r.dout == order($past(int_rdata_i), cfg.big_endian);
  endproperty
  a_read_data_with_release: assert property (p_read_data_with_release) else $error("read data not driven");

  property p_full_word;
    start && !high_byte_write_en_i |=> r.be == LANE_BOTH;
  endproperty
  a_full_word: assert property (p_full_word) else $error("full word lanes wrong");

  property p_byte_lane;
    start && high_byte_write_en_i |=> r.be == ($past(addr_in_i[ADDR_LSB]) ? LANE_HI : LANE_LO);
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte lane wrong");

  property p_space_route;
    start |=> r.space == $past(mem_reg_sel_i) && r.addr == $past(addr_in_i);
  endproperty
  a_space_route: assert property (p_space_route) else $error("space or address not latched");

  property p_no_start_before_straps;
    !cfg.valid |=> r.st == ST_IDLE;
  endproperty
  a_no_start_before_straps: assert property (p_no_start_before_straps) else $error("access before straps");

  property p_req_on_enable;
    $rose(r.req) |-> $past(cfg.bus_en);
  endproperty
  a_req_on_enable: assert property (p_req_on_enable) else $error("request off internal clock");

endmodule
`default_nettype wire

// ==== testbench/host_bus_model.sv ====
// host processor bus unit model driving the split-strobe port
// assumes the bench calls access() and that wait level follows pol_i
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
  import host_port_pkg::*;
(
  // clock and device side
  input wire logic clock_i,
  input wire logic pol_i,
  input wire logic ready_i,
  input wire logic [DATA_W-1:0] dev_data_i,
  input wire logic dev_oe_n_i,
  // host drives
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] data_o,
  output logic cs_n_o,
  output logic mem_reg_sel_o,
  output logic hb_n_o,
  output logic wr_n_o,
  output logic rd_n_o
);
  initial begin
    addr_o = ADDR_RESET;
    data_o = 16'h3C3C;
    cs_n_o = 1'b1;
    mem_reg_sel_o = 1'b0;
    hb_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
  end

  // one access; everything held until the falling edge after the edge where wait is seen released
  task automatic access(input logic we, input logic sp, input logic hb, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd, output int waits,
                        output logic ok);
    @(negedge clock_i);
    addr_o = a;
    mem_reg_sel_o = sp;
    hb_n_o = hb;
    @(negedge clock_i);
    cs_n_o = 1'b0;
    @(negedge clock_i);
    if (we) begin
      data_o = wd;
      wr_n_o = 1'b0;
    end else begin
      rd_n_o = 1'b0;
    end
    waits = 0;
    ok = 1'b0;
    rd = 16'h0000;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(posedge clock_i);
      #1;
      // stall while the port holds us, for at most 200 clocks
      if (ready_i === pol_i) begin
        waits++;
      end else if (waits > 0) begin
        ok = 1'b1;
        rd = dev_oe_n_i ? 16'hxxxx : dev_data_i;
      end
    end
    @(negedge clock_i);
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    data_o = ~data_o;  // released bus never shows the old value
  endtask
endmodule
`default_nettype wire

// ==== testbench/split_strobe_host_bus_port_tb_top.sv ====
// self-checking bench for the split-strobe host bus port
// assumes the host model above and an inline arbiter on the internal side
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module split_strobe_host_bus_port_tb_top
  import host_port_pkg::*;
();
  logic clock_i, rst_n_i, pol, div, int_req, int_we, int_space, int_ack, oe_n, ready;
  logic cs_n, msel, hb_n, wr_n, rd_n, cap_we, cap_space;
  logic [ADDR_W-1:0] addr, int_addr, cap_addr;
  logic [DATA_W-1:0] hdata, ddata, int_wdata, int_rdata, cap_wdata;
  logic [1:0] int_be, cap_be;
  int num_errors = 0;
  int total_checks = 0;
  int ack_delay = 0;
  int cnt = 0;

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  split_strobe_host_bus_port dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .endian_strap_i(1'b0),
    .hold_polarity_strap_i(pol), .clk_div_strap_i(div), .addr_in_i(addr),
    .data_io_i(oe_n ? hdata : ddata), .data_io_o(ddata), .data_io_oe_n_o(oe_n), .chip_sel_n_i(cs_n),
    .mem_reg_sel_i(msel), .high_byte_write_en_i(hb_n), .low_write_en_i(wr_n), .read_strobe_n_i(rd_n),
    .cycle_begin_n_i(1'b1), .dir_sel_n_i(1'b1), .host_ready_in_o(ready), .int_req_o(int_req),
    .int_we_o(int_we), .int_space_o(int_space), .int_addr_o(int_addr), .int_wdata_o(int_wdata),
    .int_be_o(int_be), .int_ack_i(int_ack), .int_rdata_i(int_rdata));

  host_bus_model host (.clock_i(clock_i), .pol_i(pol), .ready_i(ready), .dev_data_i(ddata),
    .dev_oe_n_i(oe_n), .addr_o(addr), .data_o(hdata), .cs_n_o(cs_n), .mem_reg_sel_o(msel),
    .hb_n_o(hb_n), .wr_n_o(wr_n), .rd_n_o(rd_n));

  // arbiter: grant after ack_delay cycles, standing in for refresh contention
  initial int_ack = 1'b0;
  initial int_rdata = 16'h0F0F;
  always @(negedge clock_i) begin
    if (int_req !== 1'b1) begin
      cnt = 0;
      int_ack = 1'b0;
    end else if (cnt >= ack_delay) begin
      int_ack = 1'b1;
    end else begin
      cnt++;
    end
    int_rdata = int_ack ? (16'h5A3C ^ int_addr[15:0]) : ~int_rdata;
  end

  // capture what the port hands over at the grant
  always @(posedge clock_i) begin
    if (int_req && int_ack) begin
      cap_we <= int_we;
      cap_space <= int_space;
      cap_addr <= int_addr;
      cap_wdata <= int_wdata;
      cap_be <= int_be;
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // waits seen by the host: d + 2 at 1:1, up to two more at 2:1 (enable phase)
  function automatic logic waits_ok(input int w, input int d);
    return div ? (w >= d + 2 && w <= d + 4) : (w == d + 2);
  endfunction

  task automatic bus(input logic we, input logic sp, input logic hb, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd, output int waits);
    logic ok;
    host.access(we, sp, hb, a, wd, rd, waits, ok);
    `CHECK(ok, 1'b1)
    if (ok !== 1'b1) complete_run();
  endtask

  // reset with given straps, then check idle levels
  task automatic t_reset(input logic p, input logic d);
    @(negedge clock_i);
    pol = p;
    div = d;
    rst_n_i = 1'b0;
    repeat (5) @(negedge clock_i);
    rst_n_i = 1'b1;
    `CHECK(ready, WAIT_PIN_RESET)
    `CHECK(int_req, 1'b0)
    repeat (3) @(negedge clock_i);
    `CHECK(ready, ~p)
    `CHECK(oe_n, 1'b1)
  endtask

  // word and high byte writes in the register space, low byte write in the memory space
  task automatic t_write_lanes();
    logic [DATA_W-1:0] rd, m;
    logic [ADDR_W-1:0] a;
    logic [1:0] be;
    int w;
    for (int k = 0; k < 3; k++) begin
      a = 18'h2A4C0 + 18'(k == 2);
      be = (k == 0) ? LANE_BOTH : (k == 1) ? LANE_LO : LANE_HI;
      m = {{8{be[1]}}, {8{be[0]}}};
      bus(1'b1, k[0], k != 0, a, 16'hC3B0 + 16'(k), rd, w);
      `CHECK(waits_ok(w, ack_delay), 1'b1)
      `CHECK(cap_we, 1'b1)
      `CHECK(cap_space, k[0])
      `CHECK(cap_addr, a)
      `CHECK(cap_be, be)
      `CHECK(cap_wdata & m, (16'hC3B0 + 16'(k)) & m)
    end
  endtask

  // word read with arbitration held off for d cycles
  task automatic t_read(input int d, input logic sp);
    logic [DATA_W-1:0] rd;
    logic [ADDR_W-1:0] a;
    int w;
    ack_delay = d;
    a = 18'h1D6E2 + 18'(d * 2);
    bus(1'b0, sp, 1'b0, a, 16'h0000, rd, w);
    `CHECK(rd, 16'h5A3C ^ a[15:0])
    `CHECK(cap_we, 1'b0)
    `CHECK(cap_space, sp)
    `CHECK(waits_ok(w, d), 1'b1)
    // data bus must be let go once the host drops its strobes
    @(negedge clock_i);
    `CHECK(oe_n, 1'b1)
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    pol = 1'b0;
    div = 1'b0;
    t_reset(1'b0, 1'b0);
    t_write_lanes();
    t_read(0, 1'b0);
    t_read(6, 1'b1);
    // second reset in mid-run: active high wait and 2:1 internal clock
    t_reset(1'b1, 1'b1);
    t_write_lanes();
    t_read(3, 1'b1);
    t_read(0, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
